// >>> fp_fraction_normalize.sv
// Normalizes a fixed-point fraction and chops or rounds it to 24 or 56 bits.
// Assumes a combinational context; the caller supplies the exponent base.
`timescale 1ns/1ps
module fp_fraction_normalize #(
	parameter int W  = 112,
	parameter int ML = 56,
	parameter int SL = 24
) (
	// Fraction in
	input  wire logic [W-1:0]  frac,
	input  wire logic          dbl,
	input  wire logic          chop,
	// Normalized out
	output logic      [ML-1:0] mant,
	output logic      [6:0]    lz,
	output logic               carry,
	output logic               zero
);
	logic [W-1:0]  sh;
	logic [ML-1:0] lmask;
	logic [ML-1:0] lsb;
	logic [ML:0]   sum;
	logic          rb;

	always_comb begin
		lz = 7'h00;
		for (int i = 0; i < W; i++) begin
			if (frac[i]) begin
				lz = 7'(W - 1 - i);
			end
		end
		sh    = frac << lz;
		zero  = ~|frac;
		lmask = dbl ? {ML{1'b1}} : ~({ML{1'b1}} >> SL);
		lsb   = dbl ? ML'(1) : ML'(1) << (ML - SL);
		rb    = dbl ? sh[W-ML-1] : sh[W-SL-1];
		sum   = {1'b0, sh[W-1 -: ML] & lmask} + ((rb & ~chop) ? {1'b0, lsb} : {(ML+1){1'b0}});
		// A carry out of the rounding gives back a mantissa of exactly one half and sets carry.
		carry = sum[ML];
		mant  = carry ? {1'b1, {(ML-1){1'b0}}} : sum[ML-1:0];
	end
endmodule // fp_fraction_normalize

// >>> fp_integerize_and_precision_convert.sv
// FP multiply-and-integerize tail and precision-convert load, with an AXI4-Lite
// register file holding the accumulators, source operand, modes and traps.
// Assumes a single 125 MHz clock and a synchronous active-low reset.
//
// Function
// - integer part goes to accumulator index OR one, fraction to destination itself.
// - significance length is 24 bits single, 56 bits double.
// - magnitude at least two to the length: chopped integer, exact zero fraction.
// - magnitude one up to two to the length: exact integer, chopped or rounded fraction.
// - rounding may return a fraction of plus or minus one.
// - single fraction error within one LSB chopped, half LSB rounded.
// - double mode may have wrong low fraction bits for large integers.
// - magnitude below one without underflow: zero integer, chopped or rounded fraction.
// - underflow with trap enabled: zero integer, fraction exponent plus 256, trap.
// - underflow with trap disabled: both accumulators get exact zero, no trap.
// - integerize clears carry, overflow only on later variant, zero and negative from fraction.
// - minus-zero source with undefined trap enabled traps before anything executes.
// - convert of a source with zero exponent yields exact zero.
// - later variant, no chop, no overflow trap, overflow: exact zero result.
// - double mode clear converts double to single, chopping or rounding.
// - double mode set loads single into upper half, lower half cleared.
// - convert clears carry, overflow on conversion overflow, zero and negative from result.
// - overflow trap enabled and rounding overflow: trap, store signed zero result.
// - single to double never overflows; no direction signals underflow.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "fpic_cfg.svh"
module fp_integerize_and_precision_convert #(
	parameter int NUM_ACC = 4,
	parameter int AW      = 8
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Write address channel
	input  wire logic [AW-1:0] awaddr,
	input  wire logic [2:0]    awprot,
	input  wire logic          awvalid,
	output logic               awready,
	// Write data channel
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	// Write response channel
	output logic      [1:0]    bresp,
	output logic               bvalid,
	input  wire logic          bready,
	// Read address channel
	input  wire logic [AW-1:0] araddr,
	input  wire logic [2:0]    arprot,
	input  wire logic          arvalid,
	output logic               arready,
	// Read data channel
	output logic      [31:0]   rdata,
	output logic      [1:0]    rresp,
	output logic               rvalid,
	input  wire logic          rready,
	// Interrupt
	output logic               irq
);
	localparam int IW = (NUM_ACC > 1) ? $clog2(NUM_ACC) : 1;

	logic [63:0]        acc [NUM_ACC];
	logic [63:0]        src;
	fpic_pkg::ctrl_t    ctrl;
	fpic_pkg::cc_t      cc;
	fpic_pkg::trap_t    istat;
	fpic_pkg::trap_t    imask;
	fpic_pkg::trap_t    next_istat;
	fpic_pkg::trap_t    next_imask;
	fpic_pkg::st_t      state;
	logic [31:0]        cmd;
	logic [AW-1:0]      aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               aw_got;
	logic               w_got;
	logic               next_aw_got;
	logic               next_w_got;
	logic               next_rvalid;
	logic               do_write;
	logic               do_read;
	logic               exec;
	logic               undef;
	fpic_pkg::op_t      cmd_op;
	logic [IW-1:0]      cmd_idx;
	logic [IW-1:0]      odd_idx;
	logic [63:0]        acc_a;

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	function automatic logic exp_zero(input logic [63:0] v);
		return v[62:55] == 8'h00;
	endfunction

	function automatic logic [63:0] pack(input logic s, input logic [7:0] e,
	                                     input logic [55:0] mt);
		return {s, e, mt[54:0]};
	endfunction

	function automatic logic acc_hit(input logic [AW-1:0] a);
		return a >= `A_ACC && a < AW'(`A_ACC + 8 * NUM_ACC);
	endfunction

	function automatic logic [IW-1:0] acc_sel(input logic [AW-1:0] a);
		return IW'((a - `A_ACC) >> 3);
	endfunction

	function automatic logic addr_ok(input logic [AW-1:0] a);
		return acc_hit(a) || a == `A_CTRL || a == `A_CMD || a == `A_CC ||
		       a == `A_ISTAT || a == `A_IMASK || a == `A_SRC_LO || a == `A_SRC_HI;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
	                                      input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// AXI4-Lite write path
	// ---------------------------------------------------------------
	assign do_write    = aw_got && w_got && !bvalid;
	assign next_aw_got = (aw_got || (awvalid && awready)) && !do_write;
	assign next_w_got  = (w_got || (wvalid && wready)) && !do_write;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			aw_got  <= next_aw_got;
			w_got   <= next_w_got;
			awready <= !next_aw_got;
			wready  <= !next_w_got;
			if (awvalid && awready) begin
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= addr_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path
	// ---------------------------------------------------------------
	assign do_read     = arvalid && arready;
	assign next_rvalid = (rvalid && !rready) || do_read;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `RESP_OKAY;
		end else begin
			arready <= !next_rvalid;
			rvalid  <= next_rvalid;
			if (do_read) begin
				rresp <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
				rdata <= 32'h0;
				case (araddr)
					`A_CTRL:   rdata <= {26'h0, ctrl};
					`A_CMD:    rdata <= cmd;
					`A_CC:     rdata <= {28'h0, cc};
					`A_ISTAT:  rdata <= {29'h0, istat};
					`A_IMASK:  rdata <= {29'h0, imask};
					`A_SRC_LO: rdata <= src[31:0];
					`A_SRC_HI: rdata <= src[63:32];
					default: begin
						if (acc_hit(araddr)) begin
							rdata <= araddr[2] ? acc[acc_sel(araddr)][63:32]
							                   : acc[acc_sel(araddr)][31:0];
						end
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Software-written control registers
	// ---------------------------------------------------------------
	// The interrupt output uses the next mask so that it follows a mask write at once.
	assign next_imask = (do_write && aw_addr == `A_IMASK) ?
	                    fpic_pkg::trap_t'(merge({29'h0, imask}, w_data, w_strb) & 32'h7) : imask;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl  <= '0;
			imask <= '0;
			src   <= 64'h0;
		end else if (do_write) begin
			if (aw_addr == `A_CTRL) begin
				ctrl <= fpic_pkg::ctrl_t'(merge({26'h0, ctrl}, w_data, w_strb) & 32'h3F);
			end
			if (aw_addr == `A_IMASK) begin
				imask <= next_imask;
			end
			if (aw_addr == `A_SRC_LO) begin
				src[31:0] <= merge(src[31:0], w_data, w_strb);
			end
			if (aw_addr == `A_SRC_HI) begin
				src[63:32] <= merge(src[63:32], w_data, w_strb);
			end
		end
	end

	// ---------------------------------------------------------------
	// Command sequencing
	// ---------------------------------------------------------------
	assign exec    = state == fpic_pkg::ST_EXEC;
	assign cmd_op  = fpic_pkg::op_t'(cmd[0]);
	assign cmd_idx = cmd[`CMD_IDX_LSB +: IW];
	assign odd_idx = cmd_idx | IW'(1);
	assign acc_a   = acc[cmd_idx];
	// With the undefined-value trap enabled, a minus-zero source aborts the operation before any state changes.
	assign undef   = ctrl.undefined_value_trap_enable && src[63] && exp_zero(src);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fpic_pkg::ST_IDLE;
			cmd   <= 32'h0;
		end else begin
			case (state)
				fpic_pkg::ST_IDLE: begin
					if (do_write && aw_addr == `A_CMD) begin
						cmd   <= merge(cmd, w_data, w_strb);
						state <= fpic_pkg::ST_EXEC;
					end
				end
				fpic_pkg::ST_EXEC: state <= fpic_pkg::ST_IDLE;
				default: state <= fpic_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Multiply and integerize
	// ---------------------------------------------------------------
	logic [55:0]  lmask;
	logic [55:0]  ma;
	logic [55:0]  mb;
	logic [111:0] p;
	logic [111:0] m;
	logic [111:0] fr;
	logic [9:0]   pe_raw;
	logic [9:0]   exp10;
	logic [6:0]   kk;
	logic [6:0]   len;
	logic         i_sign;
	logic         i_zero;
	logic         i_ovf;
	logic         i_unf;
	logic         k_pos;
	logic         k_big;
	logic [55:0]  g_mant;
	logic [6:0]   g_lz;
	logic         g_carry;
	logic         g_zero;
	logic [7:0]   g_exp;
	logic [63:0]  n_res;
	logic [63:0]  g_res;

	// Exact product is kept, so the double-mode fraction is never worse than allowed.
	always_comb begin
		len    = ctrl.double_mode_select ? `LEN_DBL : `LEN_SGL;
		lmask  = ctrl.double_mode_select ? `ALL56 : `SGL_MASK;
		ma     = {1'b1, acc_a[54:0]} & lmask;
		mb     = {1'b1, src[54:0]} & lmask;
		p      = ma * mb;
		m      = p[111] ? p : {p[110:0], 1'b0};
		pe_raw = {2'h0, acc_a[62:55]} + {2'h0, src[62:55]} - {9'h0, ~p[111]};
		exp10  = pe_raw - `EXP_BIAS;
		kk     = 7'(pe_raw - `INT_BASE);
		i_sign = acc_a[63] ^ src[63];
		i_zero = exp_zero(acc_a) || exp_zero(src);
		i_ovf  = !i_zero && pe_raw > `EXP_MAX_RAW;
		i_unf  = !i_zero && pe_raw < `EXP_MIN_RAW;
		k_pos  = pe_raw > `INT_BASE;
		k_big  = pe_raw > `INT_BASE + {3'h0, len};
		fr     = k_pos ? (m << kk) : m;
	end

	fp_fraction_normalize #(
		.W  (112),
		.ML (56),
		.SL (24)
	) u_norm (
		.frac  (fr),
		.dbl   (ctrl.double_mode_select),
		.chop  (ctrl.chop_select),
		.mant  (g_mant),
		.lz    (g_lz),
		.carry (g_carry),
		.zero  (g_zero)
	);

	always_comb begin
		// Underflowed exponents wrap, leaving them 256 too large.
		g_exp = (k_pos ? `EXP_HALF : exp10[7:0]) - {1'b0, g_lz} + {7'h0, g_carry};
		n_res = 64'h0;
		g_res = g_zero ? 64'h0 : pack(i_sign, g_exp, g_mant);
		if (i_zero || i_ovf) begin
			g_res = 64'h0;
		end else if (k_big) begin
			n_res = pack(i_sign, exp10[7:0], m[111:56] & lmask);
			g_res = 64'h0;
		end else if (k_pos) begin
			n_res = pack(i_sign, exp10[7:0], m[111:56] & ~(`ALL56 >> kk));
		end else if (i_unf && !ctrl.underflow_trap_enable) begin
			g_res = 64'h0;
		end
	end

	// ---------------------------------------------------------------
	// Precision-convert load
	// ---------------------------------------------------------------
	logic [63:0] cv_res;
	logic        cv_ovf;

	fp_precision_convert u_conv (
		.src  (src),
		.ctrl (ctrl),
		.res  (cv_res),
		.ovf  (cv_ovf)
	);

	// ---------------------------------------------------------------
	// Accumulators, condition codes, traps
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_ACC; i++) begin
				acc[i] <= 64'h0;
			end
		end else if (exec && !undef) begin
			if (cmd_op == fpic_pkg::OP_INTEGERIZE) begin
				acc[odd_idx] <= n_res;
				acc[cmd_idx] <= g_res;
			end else begin
				acc[cmd_idx] <= cv_res;
			end
		end else if (do_write && acc_hit(aw_addr)) begin
			if (aw_addr[2]) begin
				acc[acc_sel(aw_addr)][63:32] <= merge(acc[acc_sel(aw_addr)][63:32], w_data, w_strb);
			end else begin
				acc[acc_sel(aw_addr)][31:0] <= merge(acc[acc_sel(aw_addr)][31:0], w_data, w_strb);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc <= '0;
		end else if (exec && !undef) begin
			cc.fp_carry_code <= 1'b0;
			if (cmd_op == fpic_pkg::OP_INTEGERIZE) begin
				cc.fp_overflow_code <= i_ovf && ctrl.later_variant;
				cc.fp_zero_code     <= exp_zero(g_res);
				cc.fp_negative_code <= g_res[63] && !exp_zero(g_res);
			end else begin
				cc.fp_overflow_code <= cv_ovf;
				cc.fp_zero_code     <= exp_zero(cv_res);
				cc.fp_negative_code <= cv_res[63] && !exp_zero(cv_res);
			end
		end
	end

	// Reading the status clears it, but an event in the same cycle survives.
	always_comb begin
		next_istat = istat;
		if (do_read && araddr == `A_ISTAT) begin
			next_istat = '0;
		end
		if (exec && undef) begin
			next_istat.undef_trap = 1'b1;
		end
		if (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE && !i_ovf && i_unf &&
		    ctrl.underflow_trap_enable) begin
			next_istat.unf_trap = 1'b1;
		end
		if (exec && !undef && ctrl.overflow_trap_enable &&
		    ((cmd_op == fpic_pkg::OP_CONVERT && cv_ovf) ||
		     (cmd_op == fpic_pkg::OP_INTEGERIZE && i_ovf))) begin
			next_istat.ovf_trap = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			istat <= '0;
			irq   <= 1'b0;
		end else begin
			istat <= next_istat;
			irq   <= |(next_istat & next_imask);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_UNDEF_HOLDS: assert property (exec && undef |=> $stable(cc) && istat.undef_trap)
		else $error("minus-zero trap changed codes or did not flag");
	AST_CONV_ZERO: assert property (exec && !undef && cmd_op == fpic_pkg::OP_CONVERT &&
		exp_zero(src) |=> acc[cmd_idx] == 64'h0)
		else $error("zero-exponent convert not exact zero");
	AST_SGL_LOAD: assert property (exec && !undef && cmd_op == fpic_pkg::OP_CONVERT &&
		ctrl.double_mode_select && !exp_zero(src)
		|=> acc[cmd_idx] == {$past(src[63:32]), 32'h0} && !cc.fp_overflow_code)
		else $error("single load not left justified");
	AST_CONV_OVF_TRAP: assert property (exec && !undef && cmd_op == fpic_pkg::OP_CONVERT &&
		cv_ovf && ctrl.overflow_trap_enable |=> istat.ovf_trap && acc[cmd_idx][62:0] == 63'h0
		&& cc.fp_overflow_code && cc.fp_zero_code)
		else $error("conversion overflow trap missing");
	AST_FD1_NO_OVF: assert property (ctrl.double_mode_select |-> !cv_ovf)
		else $error("single to double overflowed");
	AST_CONV_CC: assert property (exec && !undef && cmd_op == fpic_pkg::OP_CONVERT
		|=> !cc.fp_carry_code && cc.fp_zero_code == exp_zero(acc[cmd_idx]))
		else $error("convert condition codes wrong");
	AST_BIG_INT: assert property (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE &&
		k_big && !i_ovf && !i_zero |=> acc[cmd_idx] == 64'h0 && cc.fp_zero_code)
		else $error("large product fraction not zero");
	AST_SUBUNITY: assert property (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE &&
		!k_pos && !cmd_idx[0] |=> acc[odd_idx] == 64'h0)
		else $error("sub-unity integer part not zero");
	AST_UNF_OFF: assert property (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE &&
		i_unf && !ctrl.underflow_trap_enable |=> acc[cmd_idx] == 64'h0 &&
		(cmd_idx[0] || acc[odd_idx] == 64'h0) && !$rose(istat.unf_trap) ##1
		!$rose(istat.unf_trap))
		else $error("untrapped underflow not cleared");
	AST_INT_CC: assert property (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE
		|=> !cc.fp_carry_code && cc.fp_overflow_code == $past(i_ovf && ctrl.later_variant))
		else $error("integerize condition codes wrong");
	AST_SGL_LEN: assert property (exec && !undef && cmd_op == fpic_pkg::OP_INTEGERIZE &&
		!ctrl.double_mode_select |=> acc[cmd_idx][31:0] == 32'h0)
		else $error("single integerize kept low bits");
	AST_IRQ: assert property (irq == |(istat & imask))
		else $error("irq does not follow unmasked status");

	CV_CASE3: cover property (exec && cmd_op == fpic_pkg::OP_INTEGERIZE && k_pos && !k_big);
	CV_CONV_OVF: cover property (exec && cmd_op == fpic_pkg::OP_CONVERT && cv_ovf);
	CV_UNF_TRAP: cover property (exec && cmd_op == fpic_pkg::OP_INTEGERIZE && i_unf ##1 irq);
endmodule // fp_integerize_and_precision_convert

// >>> fp_integerize_and_precision_convert_tb.sv
// Self-checking bench for the FP integerize and precision-convert block.
// Assumes the design files and fpic_cfg.svh are compiled alongside.
`timescale 1ns/1ps
`include "fpic_cfg.svh"
module fp_integerize_and_precision_convert_tb;
	typedef struct packed {
		logic [5:0]  ctrl;
		logic [2:0]  cmd;
		logic [3:0]  cc;
		logic [3:0]  ist;
		logic [31:0] a, sh, sl, e0, e1;
	} row_t;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_word;
	logic [1:0]  bresp, rresp, wr_resp, rd_resp;
	logic [63:0] v;
	int          fail_count, n_tests;
	row_t        rows [14];
	row_t        ovf_row;

	fp_integerize_and_precision_convert dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .irq(irq)
	);

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd_word = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd64(input logic [7:0] a);
		rd(a);
		v[31:0] = rd_word;
		rd(a + 8'h04);
		v[63:32] = rd_word;
	endtask
	task automatic run_row(input row_t r);
		wr(`A_CTRL, {26'h0, r.ctrl});
		wr(`A_ACC, 32'h0);
		wr(`A_ACC + 8'h04, r.a);
		wr(`A_ACC + 8'h08, 32'h0);
		wr(`A_ACC + 8'h0C, 32'h0);
		wr(`A_SRC_LO, r.sl);
		wr(`A_SRC_HI, r.sh);
		wr(`A_CMD, {29'h0, r.cmd});
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		#160000;
		fail_count++;
		complete_run();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		rows = '{
			'{6'h01, 3'h1, 4'h0, 4'h0, 32'h0, 32'h40800000, 32'h12345678, 32'h40800000, 32'h0},
			'{6'h02, 3'h1, 4'h0, 4'h0, 32'h0, 32'h40800000, 32'hFFFFFFFF, 32'h40800000, 32'h0},
			'{6'h00, 3'h1, 4'h0, 4'h0, 32'h0, 32'h40800000, 32'h80000000, 32'h40800001, 32'h0},
			'{6'h01, 3'h1, 4'h4, 4'h0, 32'h0, 32'h0, 32'h12345678, 32'h0, 32'h0},
			'{6'h01, 3'h1, 4'h8, 4'h0, 32'h0, 32'hC0800000, 32'h0, 32'hC0800000, 32'h0},
			'{6'h04, 3'h1, 4'h6, 4'h1, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h80000000, 32'h0},
			'{6'h20, 3'h1, 4'h6, 4'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0},
			'{6'h00, 3'h1, 4'h6, 4'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h80000000, 32'h0},
			'{6'h01, 3'h0, 4'h0, 4'h0, 32'h41400000, 32'h40C00000, 32'h0, 32'h40000000, 32'h41800000},
			'{6'h01, 3'h0, 4'h0, 4'h0, 32'h40000000, 32'h40000000, 32'h0, 32'h3F800000, 32'h0},
			'{6'h01, 3'h0, 4'h4, 4'h0, 32'h00800000, 32'h00800000, 32'h0, 32'h0, 32'h0},
			'{6'h09, 3'h0, 4'h0, 4'h2, 32'h00800000, 32'h00800000, 32'h0, 32'h40800000, 32'h0},
			'{6'h00, 3'h0, 4'h4, 4'h0, 32'h4C800000, 32'h40C00000, 32'h0, 32'h0, 32'h4CC00000},
			'{6'h01, 3'h0, 4'h8, 4'h0, 32'hC1400000, 32'h40C00000, 32'h0, 32'hC0000000, 32'hC1800000}};
		ovf_row = rows[5];
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`A_CTRL);
		chk(rd_word, 32'h0);
		chk(irq, 1'b0);
		foreach (rows[i]) begin
			run_row(rows[i]);
			rd64(`A_ACC);
			chk(v, {rows[i].e0, 32'h0});
			rd64(`A_ACC + 8'h08);
			chk(v, {rows[i].e1, 32'h0});
			rd(`A_CC);
			chk(rd_word, rows[i].cc);
			rd(`A_ISTAT);
			chk(rd_word, rows[i].ist);
			$display("Row %0d done", i);
		end
		run_row('{6'h10, 3'h1, 4'h0, 4'h0, 32'h40800000, 32'h80000000, 32'h0, 32'h0, 32'h0});
		rd64(`A_ACC);
		chk(v, 64'h4080000000000000);
		rd(`A_CC);
		chk(rd_word, 32'h8);
		rd(`A_ISTAT);
		chk(rd_word, 32'h4);
		$display("Minus-zero trap done");
		wr(`A_IMASK, 32'h1);
		run_row(ovf_row);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		rd(`A_ISTAT);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		wr(`A_IMASK, 32'h0);
		run_row(ovf_row);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(`A_ISTAT);
		chk(rd_word, 32'h1);
		$display("Interrupt done");
		wr(8'h40, 32'h1);
		chk(wr_resp, `RESP_SLVERR);
		rd(8'h40);
		chk(rd_resp, `RESP_SLVERR);
		chk(rd_word, 32'h0);
		wr(`A_CTRL, 32'h3F);
		chk(wr_resp, `RESP_OKAY);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`A_CTRL);
		chk(rd_word, 32'h0);
		chk(rd_resp, `RESP_OKAY);
		$display("Unmapped and reset done");
		complete_run();
	end
endmodule // fp_integerize_and_precision_convert_tb

// >>> fp_precision_convert.sv
// Converts a source operand between double and single precision.
// Assumes the caller has already screened the source for the minus-zero trap.
`timescale 1ns/1ps
module fp_precision_convert (
	// Operand and mode
	input  wire logic [63:0]    src,
	input  wire fpic_pkg::ctrl_t ctrl,
	// Result
	output logic      [63:0]    res,
	output logic                ovf
);
	logic [24:0] sum;
	logic [8:0]  exp9;

	always_comb begin
		sum  = {1'b0, 1'b1, src[54:32]} + {24'h000000, ~ctrl.chop_select & src[31]};
		exp9 = {1'b0, src[62:55]} + {8'h00, sum[24]};
		ovf  = 1'b0;
		if (src[62:55] == 8'h00) begin
			res = 64'h0;
		end else if (ctrl.double_mode_select) begin
			res = {src[63:32], 32'h0};
		end else begin
			ovf = exp9[8];
			// On overflow the exponent wraps to zero and the fraction is empty.
			res = {src[63], exp9[7:0], sum[24] ? 23'h0 : sum[22:0], 32'h0};
			if (ovf && ctrl.later_variant && !ctrl.chop_select && !ctrl.overflow_trap_enable) begin
				res = 64'h0;
			end
		end
	end
endmodule // fp_precision_convert

// >>> fpic_cfg.svh
// Register map, field positions and numeric constants of the FP datapath.
// Assumes inclusion by bare name from the design files.
`ifndef FPIC_CFG_SVH
`define FPIC_CFG_SVH

`define A_CTRL       8'h00
`define A_CMD        8'h04
`define A_CC         8'h08
`define A_ISTAT      8'h0C
`define A_IMASK      8'h10
`define A_SRC_LO     8'h18
`define A_SRC_HI     8'h1C
`define A_ACC        8'h20
`define CTRL_W       6
`define CMD_IDX_LSB  1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define LEN_SGL      7'h18
`define LEN_DBL      7'h38
`define SGL_MASK     56'hFF_FFFF_0000_0000
`define ALL56        56'hFF_FFFF_FFFF_FFFF
`define EXP_BIAS     10'h080
`define INT_BASE     10'h100
`define EXP_MAX_RAW  10'h17F
`define EXP_MIN_RAW  10'h081
`define EXP_HALF     8'h80

`endif

// >>> fpic_pkg.sv
// Types shared by the FP integerize and precision-convert datapath.
// Assumes nothing of its surroundings.
package fpic_pkg;
	typedef struct packed {
		logic later_variant;
		logic undefined_value_trap_enable;
		logic underflow_trap_enable;
		logic overflow_trap_enable;
		logic chop_select;
		logic double_mode_select;
	} ctrl_t;
	typedef struct packed {
		logic fp_negative_code;
		logic fp_zero_code;
		logic fp_overflow_code;
		logic fp_carry_code;
	} cc_t;
	typedef struct packed {
		logic undef_trap;
		logic unf_trap;
		logic ovf_trap;
	} trap_t;
	typedef enum logic {OP_INTEGERIZE = 1'h0, OP_CONVERT = 1'h1} op_t;
	typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_EXEC = 2'h2} st_t;
endpackage
